// ### rtl/pma_mgmt_consts.svh
// Register map, field positions, reset values and timing for PMA management.
`ifndef PMA_MGMT_CONSTS_SVH
`define PMA_MGMT_CONSTS_SVH
`define DEVAD_PMA 5'h01
`define DEVAD_VEND 5'h1f
`define MDIO_PORT_ADDR 5'h00
`define FRAME_START 2'b00
`define OP_ADDR 2'b00
`define OP_WRITE 2'b01
`define OP_READ 2'b11
`define OP_READ_INC 2'b10
`define PREAMBLE_BITS 6'd32
`define HDR_LAST 5'd13
`define FRAME_LAST 5'd31
`define ADDR_STEP 16'h0001
`define REG_PMA_CTRL 16'h0000
`define REG_PMA_STAT 16'h0001
`define REG_DEVS_LOW 16'h0005
`define REG_DEVS_HIGH 16'h0006
`define REG_CNT_HIGH 16'h8027
`define REG_CNT_LOW 16'h8028
`define REG_GEN_DONE 16'h8029
`define REG_MAC_LB 16'h8055
`define REG_SOP_CTRL 16'h805a
`define BIT_SOFT_RST 15
`define BIT_SOFT_PD 11
`define BIT_LOC_LB 0
`define BIT_LINK_LL 2
`define BIT_PD_ABLE 1
`define VAL_DEVS_LOW 16'h008b
`define VAL_DEVS_HIGH 16'hc000
`define RST_CNT_LOW 16'h0100
`define RST_CNT_HIGH 16'h0000
`define RST_GEN_DONE 16'h0000
`define RST_MAC_LB 16'h000a
`define RST_SOP_CTRL 16'h001b
`define CLK_PERIOD_NS 20
`define SOFT_RST_NS 320
`define SOFT_RST_CYCLES 5'((`SOFT_RST_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define STRAP_SETTLE 2'd2
`endif

// ### rtl/pma_mgmt_pkg.sv
// Types shared by the PMA management block.
package pma_mgmt_pkg;
  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_HDR = 6'b000010,
    ST_DECIDE = 6'b000100,
    ST_LOAD = 6'b001000,
    ST_TX = 6'b010000,
    ST_RX = 6'b100000
  } mdio_state_e;
  typedef logic [15:0] reg_word_t;
endpackage : pma_mgmt_pkg

// ### rtl/mdio_reg_if.sv
// Register access link between the serial port and the register bank.
`timescale 1ns/1ps
interface mdio_reg_if;
  logic clk_en;
  logic rd;
  logic wr;
  logic vendor;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport engine (input clk_en, rdata, output rd, wr, vendor, addr, wdata);
  modport regs (output clk_en, rdata, input rd, wr, vendor, addr, wdata);
endinterface : mdio_reg_if

// ### rtl/mdio_serial_port.sv
// Clause 45 management serial port: frame decode and read data drive.
`timescale 1ns/1ps
`include "pma_mgmt_consts.svh"
module mdio_serial_port
  import pma_mgmt_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic mdc_pin,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_n,
  mdio_reg_if.engine bus
);
  logic mdc_s1, mdc_s2, mdc_s3, dat_s1, dat_s2;
  logic [5:0] ones;
  logic [4:0] bitcnt;
  logic [13:0] hdr;
  logic [1:0] op;
  logic [15:0] rxsh, pma_addr, vend_addr;
  logic [16:0] txsh;
  logic is_vend;
  mdio_state_e state;

  wire rise = mdc_s2 & ~mdc_s3;
  wire pre_ok = ones == `PREAMBLE_BITS;
  wire [13:0] next_hdr = {hdr[12:0], dat_s2};
  wire [15:0] next_rxsh = {rxsh[14:0], dat_s2};
  wire [1:0] hdr_op = hdr[11:10];
  wire dev_pma = hdr[4:0] == `DEVAD_PMA;
  wire dev_vend = hdr[4:0] == `DEVAD_VEND;
  wire hit = hdr[13:12] == `FRAME_START && hdr[9:5] == `MDIO_PORT_ADDR
             && (dev_pma || dev_vend);
  wire is_read = hdr_op == `OP_READ || hdr_op == `OP_READ_INC;
  assign bus.vendor = is_vend;
  assign bus.addr = is_vend ? vend_addr : pma_addr;
  assign bus.wdata = rxsh;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      {mdc_s1, mdc_s2, mdc_s3, dat_s1, dat_s2} <= 5'h00;
      ones <= 6'h00;
      bitcnt <= 5'h00;
      hdr <= 14'h0000;
      op <= 2'h0;
      rxsh <= 16'h0000;
      txsh <= 17'h00000;
      pma_addr <= 16'h0000;
      vend_addr <= 16'h0000;
      is_vend <= 1'b0;
      bus.rd <= 1'b0;
      bus.wr <= 1'b0;
      mdio_out <= 1'b1;
      mdio_oe_n <= 1'b1;
      state <= ST_IDLE;
    end else if (bus.clk_en) begin
      mdc_s1 <= mdc_pin;
      mdc_s2 <= mdc_s1;
      mdc_s3 <= mdc_s2;
      dat_s1 <= mdio_in;
      dat_s2 <= dat_s1;
      bus.rd <= 1'b0;
      bus.wr <= 1'b0;
      case (state)
        ST_IDLE: begin
          mdio_oe_n <= 1'b1;
          if (rise && dat_s2 && !pre_ok) begin
            ones <= ones + 6'h01;
          end else if (rise && !dat_s2) begin
            ones <= 6'h00;
            if (pre_ok) begin
              hdr <= next_hdr;
              bitcnt <= 5'h01;
              state <= ST_HDR;
            end
          end
        end
        ST_HDR: begin
          if (rise) begin
            hdr <= next_hdr;
            bitcnt <= bitcnt + 5'h01;
            if (bitcnt == `HDR_LAST) begin
              state <= ST_DECIDE;
            end
          end
        end
        ST_DECIDE: begin
          is_vend <= dev_vend;
          op <= hdr_op;
          if (!hit) begin
            state <= ST_IDLE;
          end else if (is_read) begin
            bus.rd <= 1'b1;
            state <= ST_LOAD;
          end else begin
            state <= ST_RX;
          end
        end
        ST_LOAD: begin
          txsh <= {1'b0, bus.rdata};
          if (op == `OP_READ_INC && is_vend) begin
            vend_addr <= vend_addr + `ADDR_STEP;
          end else if (op == `OP_READ_INC) begin
            pma_addr <= pma_addr + `ADDR_STEP;
          end
          state <= ST_TX;
        end
        ST_TX: begin
          if (rise) begin
            bitcnt <= bitcnt + 5'h01;
            if (bitcnt == `FRAME_LAST) begin
              mdio_oe_n <= 1'b1;
              state <= ST_IDLE;
            end else begin
              mdio_out <= txsh[16];
              txsh <= {txsh[15:0], 1'b0};
              mdio_oe_n <= 1'b0;
            end
          end
        end
        ST_RX: begin
          if (rise) begin
            rxsh <= next_rxsh;
            bitcnt <= bitcnt + 5'h01;
            if (bitcnt == `FRAME_LAST) begin
              state <= ST_IDLE;
              if (op == `OP_WRITE) begin
                bus.wr <= 1'b1;
              end else if (is_vend) begin
                vend_addr <= next_rxsh;
              end else begin
                pma_addr <= next_rxsh;
              end
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule : mdio_serial_port

// ### rtl/pma_pmd_mgmt_registers.sv
// PMA/PMD and vendor management registers behind a Clause 45 serial port.
//
// How it works
// - Writing one to control bit 15 reinitialises the whole chip.
// - Soft reset bit reads one while reset runs, then clears itself.
// - Soft power-down bit puts the chip into its low-power mode.
// - Management access to every register keeps working while powered down.
// - Soft power-down reset value follows the power-down strap pin.
// - Control register reset value depends on sampled strap pin settings.
// - Local loopback returns transmit data on the receive path.
// - Link status latches low until read; reads one while link is up.
// - Power-down capability bit always reads one.
// - First devices-in-package word reads 0x008b.
// - Second devices-in-package word reads 0xc000.
// - Frame count low word is read/write and resets to 256.
// - Generator finished register is read-only and resets to zero.
// - MAC-side loopback configuration is read/write, resetting to 0x000a.
// - Start-of-packet control is read/write, resetting to 0x001b.
// - Frame count high word forms the upper half of the count.
`timescale 1ns/1ps
`include "pma_mgmt_consts.svh"
module pma_pmd_mgmt_registers
  import pma_mgmt_pkg::*;
(
  input wire logic clock,
  input wire logic clk_en,
  input wire logic sys_rst,
  input wire logic mdc_pin,
  input wire logic mdio_in,
  output logic mdio_out,
  output logic mdio_oe_n,
  input wire logic powerdown_strap_pin,
  input wire logic link_up,
  input wire logic gen_done,
  input wire logic [3:0] tx_nibble,
  input wire logic tx_valid,
  input wire logic [3:0] line_rx_nibble,
  input wire logic line_rx_valid,
  output logic [3:0] rx_nibble,
  output logic rx_valid,
  output logic chip_reset,
  output logic low_power,
  output logic local_loopback_enable,
  output logic [31:0] gen_frame_count,
  output logic [15:0] mac_side_loopback_cfg,
  output logic [15:0] packet_start_gen_ctrl
);
  mdio_reg_if bus ();

  mdio_serial_port port (
    .clock(clock),
    .sys_rst(sys_rst),
    .mdc_pin(mdc_pin),
    .mdio_in(mdio_in),
    .mdio_out(mdio_out),
    .mdio_oe_n(mdio_oe_n),
    .bus(bus)
  );

  logic strap_s1, strap_s2;
  logic [1:0] settle;
  logic strap_done;
  logic [4:0] rst_cnt;
  logic soft_powerdown;
  logic link_up_latched_low;
  logic gen_finished;
  reg_word_t gen_frame_count_low, gen_frame_count_high;

  assign bus.clk_en = clk_en;

  // Defaults are loaded once the strap has settled after reset release, and
  // held for the whole soft reset so writes during it have no effect.
  wire strap_load = !strap_done && settle == `STRAP_SETTLE;
  wire reset_busy = rst_cnt != 5'h00;
  wire load_defaults = strap_load || reset_busy;

  wire sel_ctrl = !bus.vendor && bus.addr == `REG_PMA_CTRL;
  wire sel_stat = !bus.vendor && bus.addr == `REG_PMA_STAT;
  wire sel_devs_low = !bus.vendor && bus.addr == `REG_DEVS_LOW;
  wire sel_devs_high = !bus.vendor && bus.addr == `REG_DEVS_HIGH;
  wire sel_cnt_high = bus.vendor && bus.addr == `REG_CNT_HIGH;
  wire sel_cnt_low = bus.vendor && bus.addr == `REG_CNT_LOW;
  wire sel_done = bus.vendor && bus.addr == `REG_GEN_DONE;
  wire sel_mac_lb = bus.vendor && bus.addr == `REG_MAC_LB;
  wire sel_sop = bus.vendor && bus.addr == `REG_SOP_CTRL;

  wire wr_ok = bus.wr && !reset_busy;
  wire wr_ctrl = wr_ok && sel_ctrl;
  wire start_reset = wr_ctrl && bus.wdata[`BIT_SOFT_RST];
  wire rd_stat = bus.rd && sel_stat;

  reg_word_t ctrl_word, stat_word, done_word;
  always_comb begin
    ctrl_word = 16'h0000;
    ctrl_word[`BIT_SOFT_RST] = reset_busy;
    ctrl_word[`BIT_SOFT_PD] = soft_powerdown;
    ctrl_word[`BIT_LOC_LB] = local_loopback_enable;
    stat_word = 16'h0000;
    stat_word[`BIT_LINK_LL] = link_up_latched_low;
    stat_word[`BIT_PD_ABLE] = 1'b1;
    done_word = 16'h0000;
    done_word[0] = gen_finished;
  end

  // Unmapped addresses read as zero.
  assign bus.rdata = ({16{sel_ctrl}} & ctrl_word)
    | ({16{sel_stat}} & stat_word)
    | ({16{sel_devs_low}} & `VAL_DEVS_LOW)
    | ({16{sel_devs_high}} & `VAL_DEVS_HIGH)
    | ({16{sel_cnt_high}} & gen_frame_count_high)
    | ({16{sel_cnt_low}} & gen_frame_count_low)
    | ({16{sel_done}} & done_word)
    | ({16{sel_mac_lb}} & mac_side_loopback_cfg)
    | ({16{sel_sop}} & packet_start_gen_ctrl);

  assign chip_reset = reset_busy;
  assign low_power = soft_powerdown;
  assign gen_frame_count = {gen_frame_count_high, gen_frame_count_low};

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      strap_s1 <= 1'b0;
      strap_s2 <= 1'b0;
      settle <= 2'h0;
      strap_done <= 1'b0;
    end else if (clk_en) begin
      strap_s1 <= powerdown_strap_pin;
      strap_s2 <= strap_s1;
      if (settle != `STRAP_SETTLE) begin
        settle <= settle + 2'h1;
      end
      if (strap_load) begin
        strap_done <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rst_cnt <= 5'h00;
    end else if (clk_en && start_reset) begin
      rst_cnt <= `SOFT_RST_CYCLES;
    end else if (clk_en && reset_busy) begin
      rst_cnt <= rst_cnt - 5'h01;
    end
  end

  // Control register: the power-down default comes from the strap; the loopback default is a fixed zero.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      soft_powerdown <= 1'b0;
      local_loopback_enable <= 1'b0;
    end else if (clk_en && load_defaults) begin
      soft_powerdown <= strap_s2;
      local_loopback_enable <= 1'b0;
    end else if (clk_en && wr_ctrl) begin
      soft_powerdown <= bus.wdata[`BIT_SOFT_PD];
      local_loopback_enable <= bus.wdata[`BIT_LOC_LB];
    end
  end

  // A drop in the same cycle as the read still leaves the bit low.
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      link_up_latched_low <= 1'b0;
    end else if (clk_en && load_defaults) begin
      link_up_latched_low <= 1'b0;
    end else if (clk_en && rd_stat) begin
      link_up_latched_low <= link_up;
    end else if (clk_en) begin
      link_up_latched_low <= link_up_latched_low & link_up;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      gen_finished <= 1'b0;
    end else if (clk_en) begin
      gen_finished <= !load_defaults && gen_done;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      gen_frame_count_low <= `RST_CNT_LOW;
      gen_frame_count_high <= `RST_CNT_HIGH;
      mac_side_loopback_cfg <= `RST_MAC_LB;
      packet_start_gen_ctrl <= `RST_SOP_CTRL;
    end else if (clk_en && load_defaults) begin
      gen_frame_count_low <= `RST_CNT_LOW;
      gen_frame_count_high <= `RST_CNT_HIGH;
      mac_side_loopback_cfg <= `RST_MAC_LB;
      packet_start_gen_ctrl <= `RST_SOP_CTRL;
    end else if (clk_en && wr_ok) begin
      if (sel_cnt_low) gen_frame_count_low <= bus.wdata;
      if (sel_cnt_high) gen_frame_count_high <= bus.wdata;
      if (sel_mac_lb) mac_side_loopback_cfg <= bus.wdata;
      if (sel_sop) packet_start_gen_ctrl <= bus.wdata;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      rx_nibble <= 4'h0;
      rx_valid <= 1'b0;
    end else if (clk_en && local_loopback_enable) begin
      rx_nibble <= tx_nibble;
      rx_valid <= tx_valid;
    end else if (clk_en) begin
      rx_nibble <= line_rx_nibble;
      rx_valid <= line_rx_valid;
    end
  end

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  soft_rst_start_a: assert property (
    clk_en && start_reset |=> chip_reset && bus.rdata[15] == sel_ctrl)
    else $error("soft reset did not start");

  soft_rst_clear_a: assert property (
    clk_en && rst_cnt == 5'h01 |=> !chip_reset ##0 !ctrl_word[15])
    else $error("soft reset bit did not clear");

  soft_rst_hold_a: assert property (
    clk_en && chip_reset && rst_cnt > 5'h01 |=> chip_reset)
    else $error("soft reset ended early");

  pd_write_a: assert property (
    clk_en && wr_ctrl && !start_reset
    |=> low_power == $past(bus.wdata[11]))
    else $error("power-down bit not written");

  pd_access_a: assert property (
    clk_en && low_power && wr_ok && sel_cnt_low
    |=> gen_frame_count[15:0] == $past(bus.wdata))
    else $error("write lost during power-down");

  strap_default_a: assert property (
    clk_en && strap_load |=> low_power == $past(strap_s2)
    && !local_loopback_enable)
    else $error("power-down default does not follow strap");

  ctrl_default_a: assert property (
    clk_en && reset_busy |=> ctrl_word[14:0] == {3'h0, strap_s2, 11'h000}
    || $past(strap_s2) != strap_s2)
    else $error("control default wrong during reset");

  // The edge that releases reset still finds the receive flops held in
  // reset, so no attempt may start while reset is sampled high.
  loopback_path_a: assert property (
    clk_en && !sys_rst && local_loopback_enable
    |=> rx_nibble == $past(tx_nibble))
    else $error("loopback did not return transmit data");

  normal_path_a: assert property (
    clk_en && !sys_rst && !local_loopback_enable
    |=> rx_nibble == $past(line_rx_nibble))
    else $error("normal receive path broken");

  link_drop_a: assert property (
    clk_en && !link_up ##1 !(clk_en && rd_stat && link_up)[*2]
    |-> !link_up_latched_low)
    else $error("link drop not latched");

  link_read_a: assert property (
    clk_en && rd_stat && link_up && !load_defaults |=> link_up_latched_low)
    else $error("link status not refreshed by read");

  pd_able_a: assert property (
    sel_stat |-> bus.rdata[1] && bus.rdata[0] == 1'b0)
    else $error("capability bit not one");

  devs_words_a: assert property (
    sel_devs_low |-> bus.rdata == 16'h008b)
    else $error("devices word one wrong");

  devs_high_a: assert property (
    sel_devs_high |-> bus.rdata == 16'hc000)
    else $error("devices word two wrong");

  count_default_a: assert property (
    clk_en && load_defaults |=> gen_frame_count == 32'h0000_0100
    && mac_side_loopback_cfg == 16'h000a)
    else $error("vendor defaults wrong");

  done_ro_a: assert property (
    clk_en && wr_ok && sel_done |=> gen_finished == $past(gen_done))
    else $error("finished register was written");

  sop_default_a: assert property (
    clk_en && load_defaults |=> packet_start_gen_ctrl == 16'h001b)
    else $error("start-of-packet default wrong");

  count_high_a: assert property (
    clk_en && wr_ok && sel_cnt_high
    |=> gen_frame_count[31:16] == $past(bus.wdata))
    else $error("count high word not written");

  reserved_zero_a: assert property (
    sel_ctrl |-> bus.rdata[14:12] == 3'h0 && bus.rdata[10:1] == 10'h000)
    else $error("reserved control bits not zero");

  soft_reset_c: cover property (clk_en && start_reset);
  loopback_c: cover property (local_loopback_enable && tx_valid);
  link_drop_c: cover property (!link_up ##[1:40] rd_stat);
  powered_write_c: cover property (low_power && wr_ok);
endmodule : pma_pmd_mgmt_registers

// ### tb/mdio_host_model.sv
// Host management controller model that sends Clause 45 frames.
`timescale 1ns/1ps
`include "pma_mgmt_consts.svh"
module mdio_host_model (
  input wire logic clock,
  output logic mdc_pin,
  output logic mdio_in,
  input wire logic mdio_out,
  input wire logic mdio_oe_n
);
  logic host_oe;
  logic host_out;

  // The data line has a pull-up, so it reads high when nobody drives it.
  assign mdio_in = !mdio_oe_n ? mdio_out : (host_oe ? host_out : 1'b1);

  initial begin
    mdc_pin = 1'b0;
    host_oe = 1'b0;
    host_out = 1'b1;
  end

  // Data changes while the serial clock is low and is sampled at its rise.
  task automatic bit_cycle(input logic drive, input logic val,
                           output logic seen);
    @(posedge clock);
    mdc_pin <= 1'b0;
    host_oe <= drive;
    host_out <= val;
    repeat (3) @(posedge clock);
    seen = mdio_in;
    mdc_pin <= 1'b1;
    repeat (3) @(posedge clock);
  endtask : bit_cycle

  task automatic frame(input logic [1:0] op, input logic [4:0] devad,
                       input logic [15:0] wdata, output logic [15:0] rdata);
    logic [13:0] hdr;
    logic drv;
    logic seen;
    hdr = {`FRAME_START, op, `MDIO_PORT_ADDR, devad};
    drv = (op == `OP_ADDR) || (op == `OP_WRITE);
    for (int i = 0; i < 32; i++) begin
      bit_cycle(1'b1, 1'b1, seen);
    end
    for (int i = 13; i >= 0; i--) begin
      bit_cycle(1'b1, hdr[i], seen);
    end
    bit_cycle(drv, 1'b1, seen);
    bit_cycle(drv, 1'b0, seen);
    for (int i = 15; i >= 0; i--) begin
      bit_cycle(drv, wdata[i], seen);
      rdata[i] = seen;
    end
    // The serial clock stands still and the line is released between frames.
    @(posedge clock);
    mdc_pin <= 1'b0;
    host_oe <= 1'b0;
    repeat (4) @(posedge clock);
  endtask : frame
endmodule : mdio_host_model

// ### tb/testbench.sv
// Self-checking bench for the PMA management register block.
`timescale 1ns/1ps
`include "pma_mgmt_consts.svh"
module testbench;
  import pma_mgmt_pkg::*;
  logic clock, sys_rst, clk_en, mdc_pin, mdio_in, mdio_out, mdio_oe_n;
  logic powerdown_strap_pin, link_up, gen_done, tx_valid, line_rx_valid;
  logic rx_valid, chip_reset, low_power, local_loopback_enable;
  logic [3:0] tx_nibble, line_rx_nibble, rx_nibble;
  logic [31:0] gen_frame_count;
  reg_word_t mac_side_loopback_cfg, packet_start_gen_ctrl;
  int mismatches, n_tests, rst_len;

  pma_pmd_mgmt_registers dut (.clock(clock), .clk_en(clk_en),
    .sys_rst(sys_rst), .mdc_pin(mdc_pin), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
    .powerdown_strap_pin(powerdown_strap_pin), .link_up(link_up),
    .gen_done(gen_done), .tx_nibble(tx_nibble), .tx_valid(tx_valid),
    .line_rx_nibble(line_rx_nibble), .line_rx_valid(line_rx_valid),
    .rx_nibble(rx_nibble), .rx_valid(rx_valid), .chip_reset(chip_reset),
    .low_power(low_power), .local_loopback_enable(local_loopback_enable),
    .gen_frame_count(gen_frame_count),
    .mac_side_loopback_cfg(mac_side_loopback_cfg),
    .packet_start_gen_ctrl(packet_start_gen_ctrl));

  mdio_host_model host (.clock(clock), .mdc_pin(mdc_pin), .mdio_in(mdio_in),
    .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  always @(posedge clock) begin
    if (chip_reset === 1'b1) begin
      rst_len = rst_len + 1;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic access(input logic vendor, input logic [1:0] op,
                        input reg_word_t addr, input reg_word_t data,
                        output reg_word_t got);
    logic [4:0] devad;
    reg_word_t unused;
    devad = vendor ? `DEVAD_VEND : `DEVAD_PMA;
    host.frame(`OP_ADDR, devad, addr, unused);
    host.frame(op, devad, data, got);
  endtask : access

  task automatic wr(input logic vendor, input reg_word_t addr,
                    input reg_word_t data);
    reg_word_t unused;
    access(vendor, `OP_WRITE, addr, data, unused);
  endtask : wr

  task automatic rd_chk(input logic vendor, input reg_word_t addr,
                        input reg_word_t exp);
    reg_word_t got;
    access(vendor, `OP_READ, addr, 16'h0000, got);
    chk({16'h0000, got}, {16'h0000, exp});
  endtask : rd_chk

  task automatic apply_reset;
    sys_rst <= 1'b1;
    repeat (5) @(posedge clock);
    sys_rst <= 1'b0;
    repeat (8) @(posedge clock);
  endtask : apply_reset

  task automatic test_reset_values;
    chk(gen_frame_count, 32'h0000_0100);
    rd_chk(1'b0, `REG_PMA_CTRL, 16'h0000);
    rd_chk(1'b0, `REG_PMA_STAT, 16'h0002);
    rd_chk(1'b0, `REG_DEVS_LOW, 16'h008b);
    rd_chk(1'b0, `REG_DEVS_HIGH, 16'hc000);
    rd_chk(1'b1, `REG_CNT_HIGH, 16'h0000);
    rd_chk(1'b1, `REG_CNT_LOW, 16'h0100);
    rd_chk(1'b1, `REG_GEN_DONE, 16'h0000);
    rd_chk(1'b1, `REG_MAC_LB, 16'h000a);
    rd_chk(1'b1, `REG_SOP_CTRL, 16'h001b);
  endtask : test_reset_values

  // A read with increment moves the pointer, so a bare read hits the next word.
  task automatic test_read_inc;
    reg_word_t got;
    access(1'b1, `OP_READ_INC, `REG_CNT_HIGH, 16'h0000, got);
    chk({16'h0000, got}, 32'h0000_0000);
    host.frame(`OP_READ, `DEVAD_VEND, 16'h0000, got);
    chk({16'h0000, got}, 32'h0000_0100);
  endtask : test_read_inc

  task automatic test_writes;
    wr(1'b1, `REG_CNT_HIGH, 16'hbeef);
    wr(1'b1, `REG_CNT_LOW, 16'h0003);
    wr(1'b1, `REG_MAC_LB, 16'h5a5a);
    wr(1'b1, `REG_SOP_CTRL, 16'ha5a5);
    wr(1'b1, `REG_GEN_DONE, 16'hffff);
    wr(1'b0, `REG_DEVS_LOW, 16'h1234);
    wr(1'b1, 16'h8030, 16'hffff);
    wr(1'b0, `REG_PMA_CTRL, 16'h77fe);
    chk(gen_frame_count, 32'hbeef_0003);
    chk(32'(mac_side_loopback_cfg), 32'h0000_5a5a);
    chk(32'(packet_start_gen_ctrl), 32'h0000_a5a5);
    rd_chk(1'b1, `REG_CNT_LOW, 16'h0003);
    rd_chk(1'b1, `REG_SOP_CTRL, 16'ha5a5);
    rd_chk(1'b1, `REG_GEN_DONE, 16'h0000);
    rd_chk(1'b0, `REG_DEVS_LOW, 16'h008b);
    rd_chk(1'b1, 16'h8030, 16'h0000);
    rd_chk(1'b0, `REG_PMA_CTRL, 16'h0000);
  endtask : test_writes

  task automatic test_loopback;
    tx_nibble <= 4'h9;
    tx_valid <= 1'b1;
    line_rx_nibble <= 4'h6;
    line_rx_valid <= 1'b0;
    wr(1'b0, `REG_PMA_CTRL, 16'h0001);
    chk(32'(local_loopback_enable), 32'h1);
    #1;
    chk(32'({rx_valid, rx_nibble}), 32'h19);
    wr(1'b0, `REG_PMA_CTRL, 16'h0000);
    #1;
    chk(32'({rx_valid, rx_nibble}), 32'h06);
  endtask : test_loopback

  task automatic test_powerdown;
    wr(1'b0, `REG_PMA_CTRL, 16'h0800);
    chk(32'(low_power), 32'h1);
    rd_chk(1'b0, `REG_PMA_CTRL, 16'h0800);
    wr(1'b1, `REG_SOP_CTRL, 16'h0033);
    rd_chk(1'b1, `REG_SOP_CTRL, 16'h0033);
    wr(1'b0, `REG_PMA_CTRL, 16'h0000);
    chk(32'(low_power), 32'h0);
  endtask : test_powerdown

  task automatic test_link_and_done;
    link_up <= 1'b1;
    rd_chk(1'b0, `REG_PMA_STAT, 16'h0002);
    rd_chk(1'b0, `REG_PMA_STAT, 16'h0006);
    link_up <= 1'b0;
    repeat (2) @(posedge clock);
    link_up <= 1'b1;
    gen_done <= 1'b1;
    rd_chk(1'b0, `REG_PMA_STAT, 16'h0002);
    rd_chk(1'b0, `REG_PMA_STAT, 16'h0006);
    rd_chk(1'b1, `REG_GEN_DONE, 16'h0001);
    gen_done <= 1'b0;
    // A drop while the clock enable is low is never seen by the latch.
    clk_en <= 1'b0;
    link_up <= 1'b0;
    repeat (3) @(posedge clock);
    clk_en <= 1'b1;
    link_up <= 1'b1;
    rd_chk(1'b0, `REG_PMA_STAT, 16'h0006);
  endtask : test_link_and_done

  task automatic test_soft_reset;
    wr(1'b0, `REG_PMA_CTRL, 16'h0001);
    rst_len = 0;
    wr(1'b0, `REG_PMA_CTRL, 16'h8001);
    for (int i = 0; i < 40 && chip_reset !== 1'b0; i++) begin
      @(posedge clock);
    end
    chk(32'(rst_len), 32'd16);
    chk(gen_frame_count, 32'h0000_0100);
    chk(32'(local_loopback_enable), 32'h0);
    rd_chk(1'b0, `REG_PMA_CTRL, 16'h0000);
  endtask : test_soft_reset

  task automatic test_strap;
    powerdown_strap_pin <= 1'b1;
    apply_reset;
    chk(32'(low_power), 32'h1);
    rd_chk(1'b0, `REG_PMA_CTRL, 16'h0800);
    powerdown_strap_pin <= 1'b0;
    apply_reset;
    chk(32'(low_power), 32'h0);
  endtask : test_strap

  task automatic results;
    if (mismatches == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results

  // About twice the expected length of the whole run.
  initial begin
    repeat (75000) @(posedge clock);
    mismatches++;
    results;
  end

  initial begin
    mismatches = 0;
    n_tests = 0;
    rst_len = 0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    powerdown_strap_pin = 1'b0;
    link_up = 1'b0;
    gen_done = 1'b0;
    tx_nibble = 4'h0;
    tx_valid = 1'b0;
    line_rx_nibble = 4'h0;
    line_rx_valid = 1'b0;
    apply_reset;
    test_reset_values;
    test_read_inc;
    test_writes;
    test_loopback;
    test_powerdown;
    test_link_and_done;
    test_soft_reset;
    test_strap;
    results;
  end
endmodule : testbench
